// *** irf_core_model.sv ***
// Core partner that accepts vectored requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module irf_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_req,
  input  wire logic [4:0] core_vec,
  input  wire logic [3:0] ack_dly,
  output logic            core_ack,
  output logic      [4:0] last_vec,
  output int              n_acc
);
  logic [3:0] wait_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      wait_ff  <= 4'h0;
      last_vec <= 5'h00;
      n_acc    <= 0;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      wait_ff  <= 4'h0;
    end else if (core_req && wait_ff >= ack_dly) begin
      core_ack <= 1'b1;
      last_vec <= core_vec;
      n_acc    <= n_acc + 1;
    end else if (core_req) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** irf_ctrl.sv ***
// Interrupt request flags, enables, priority and vector issue with APB
`timescale 1ns/1ns
`default_nettype none

module irf_ctrl #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [4:0]           ext_req_pin_n,
  input  wire logic [7:0]           wake_pin_n,
  input  wire irf_pkg::irf_periph_t periph,
  input  wire irf_pkg::irf_timer_t  timer,
  input  wire logic                 core_ack,
  output logic                      core_req,
  output logic      [4:0]           core_vec
);

  ////////////////////////////////////////////////////////////////////////////
  // Variant masks
  localparam logic [4:0] EXT_AVAIL =
    FULL_VARIANT ? irf_pkg::EXT_FULL : irf_pkg::EXT_REDUCED;
  localparam logic [7:0] REQ1_AVAIL =
    FULL_VARIANT ? irf_pkg::REQ1_IMPL
                 : (irf_pkg::REQ1_IMPL & irf_pkg::REQ1_REDUCED);
  localparam logic [7:0] REQ2_AVAIL =
    FULL_VARIANT ? irf_pkg::REQ2_IMPL
                 : (irf_pkg::REQ2_IMPL & irf_pkg::REQ2_REDUCED);

  irf_pkg::irf_state_t s_ff;
  irf_pkg::irf_state_t nxt_s;

  logic [irf_pkg::NUM_PINS-1:0] pin_rise;
  logic [irf_pkg::NUM_PINS-1:0] pin_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // sync before edge
  irf_pin_sync #(
    .W (irf_pkg::NUM_PINS)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_n   ({wake_pin_n, ext_req_pin_n}),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [31:0]                 rdata;
    logic                        err;
    logic                        wr;
    logic [7:0]                  clr;
    logic [4:0]                  ext_edge;
    logic [7:0]                  set1;
    logic [7:0]                  set2;
    logic [7:0]                  setw;
    logic                        match_h;
    logic                        match_l;
    logic                        updown_wrap;
    logic                        interval_wrap;
    logic                        timer_a_wrap;
    logic [irf_pkg::NUM_SRC-1:0] pend;
    logic                        found;
    logic [4:0]                  sel;

    rdata         = irf_pkg::RDATA_RST;
    err           = 1'b0;
    wr            = 1'b0;
    clr           = 8'h00;
    ext_edge      = 5'h00;
    set1          = 8'h00;
    set2          = 8'h00;
    setw          = 8'h00;
    match_h       = 1'b0;
    match_l       = 1'b0;
    updown_wrap   = 1'b0;
    interval_wrap = 1'b0;
    timer_a_wrap  = 1'b0;
    pend          = '0;
    found         = 1'b0;
    sel           = 5'h00;
    nxt_s         = s_ff;

    //////////////////////////////////////////////////////////////////////////
    // Read decode
    case (paddr)
      irf_pkg::ADDR_REQ_ONE: begin
        rdata[7:0] = s_ff.req_one;
        rdata[irf_pkg::REQ1_FIXED_ONE] = 1'b1;
      end
      irf_pkg::ADDR_REQ_TWO: begin
        rdata[7:0] = s_ff.req_two;
      end
      irf_pkg::ADDR_WAKE_REQ: begin
        rdata[7:0] = s_ff.wake_req;
      end
      irf_pkg::ADDR_EN_ONE: begin
        rdata[7:0] = s_ff.en_one;
      end
      irf_pkg::ADDR_EN_TWO: begin
        rdata[7:0] = s_ff.en_two;
      end
      irf_pkg::ADDR_EDGE_SEL: begin
        rdata[4:0] = s_ff.edge_sel;
      end
      irf_pkg::ADDR_PIN_MODE: begin
        rdata[4:0]  = s_ff.pmode_ext;
        rdata[15:8] = s_ff.pmode_wake;
      end
      irf_pkg::ADDR_CORE_STAT: begin
        rdata[irf_pkg::STAT_IMASK] = s_ff.imask;
        rdata[irf_pkg::STAT_REQ]   = s_ff.core_req;
        rdata[irf_pkg::STAT_VEC_LSB +: 5] = s_ff.core_vec;
      end
      default: begin
        err = 1'b1;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait cycle, write lands at the completing edge
    wr = psel & penable & pwrite & s_ff.pready;
    if (psel & penable & ~s_ff.pready) begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = err;
      if (!pwrite) begin
        nxt_s.prdata = rdata;
      end
    end else begin
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
    end
    clr = ~pwdata[7:0];

    //////////////////////////////////////////////////////////////////////////
    // Set events from peripherals
    // high compare match
    if (timer.sixteen_bit) begin
      match_h = {timer.cnt_high, timer.cnt_low}
             == {timer.cmp_high, timer.cmp_low};
    end else begin
      match_h = timer.cnt_high == timer.cmp_high;
    end
    match_l = ~timer.sixteen_bit & (timer.cnt_low == timer.cmp_low);
    nxt_s.match_h_prev = match_h;
    nxt_s.match_l_prev = match_l;

    updown_wrap =
      ((s_ff.updown_prev == irf_pkg::CNT_TOP)
        && (timer.updown_cnt == irf_pkg::CNT_ZERO))
      || ((s_ff.updown_prev == irf_pkg::CNT_ZERO)
        && (timer.updown_cnt == irf_pkg::CNT_TOP));
    interval_wrap = (s_ff.interval_prev == irf_pkg::CNT_TOP)
                 && (timer.interval_cnt == irf_pkg::CNT_ZERO);
    timer_a_wrap  = (s_ff.timer_a_prev == irf_pkg::CNT_TOP)
                 && (timer.timer_a_cnt == irf_pkg::CNT_ZERO);
    nxt_s.updown_prev   = timer.updown_cnt;
    nxt_s.interval_prev = timer.interval_cnt;
    nxt_s.timer_a_prev  = timer.timer_a_cnt;
    nxt_s.conv_prev     = periph.conversion_start_status;

    set2[irf_pkg::REQ2_DIRECT] = periph.direct_xfer_evt
                               & periph.direct_xfer_on;
    set2[irf_pkg::REQ2_CONV] = s_ff.conv_prev
                             & ~periph.conversion_start_status;
    set2[irf_pkg::REQ2_CMP_HIGH] = match_h & ~s_ff.match_h_prev;
    set2[irf_pkg::REQ2_CMP_LOW]  = match_l & ~s_ff.match_l_prev;
    set2[irf_pkg::REQ2_UPDOWN]   = updown_wrap;
    set2[irf_pkg::REQ2_INTERVAL] = interval_wrap;
    set2 = set2 & REQ2_AVAIL;

    ext_edge = (s_ff.edge_sel & pin_rise[irf_pkg::NUM_EXT-1:0])
             | (~s_ff.edge_sel & pin_fall[irf_pkg::NUM_EXT-1:0]);
    set1[4:0] = ext_edge & s_ff.pmode_ext & EXT_AVAIL;
    set1[irf_pkg::REQ1_SERIAL]  = periph.serial1_done;
    set1[irf_pkg::REQ1_TIMER_A] = timer_a_wrap;
    set1 = set1 & REQ1_AVAIL;

    setw = pin_fall[irf_pkg::NUM_PINS-1:irf_pkg::NUM_EXT] & s_ff.pmode_wake;

    //////////////////////////////////////////////////////////////////////////
    // Flag registers
    // write zero clears
    if (wr && (paddr == irf_pkg::ADDR_REQ_ONE)) begin
      nxt_s.req_one = (s_ff.req_one & ~clr & REQ1_AVAIL) | set1;
    end else begin
      nxt_s.req_one = s_ff.req_one | set1;
    end
    if (wr && (paddr == irf_pkg::ADDR_REQ_TWO)) begin
      nxt_s.req_two = (s_ff.req_two & ~clr & REQ2_AVAIL) | set2;
    end else begin
      nxt_s.req_two = s_ff.req_two | set2;
    end
    if (wr && (paddr == irf_pkg::ADDR_WAKE_REQ)) begin
      nxt_s.wake_req = (s_ff.wake_req & ~clr) | setw;
    end else begin
      nxt_s.wake_req = s_ff.wake_req | setw;
    end

    //////////////////////////////////////////////////////////////////////////
    // Control registers
    if (wr && (paddr == irf_pkg::ADDR_EN_ONE)) begin
      nxt_s.en_one = pwdata[7:0] & {REQ1_AVAIL[7:6], 1'b1, EXT_AVAIL};
    end
    if (wr && (paddr == irf_pkg::ADDR_EN_TWO)) begin
      nxt_s.en_two = pwdata[7:0] & REQ2_AVAIL;
    end
    if (wr && (paddr == irf_pkg::ADDR_EDGE_SEL)) begin
      nxt_s.edge_sel = pwdata[4:0];
    end
    if (wr && (paddr == irf_pkg::ADDR_PIN_MODE)) begin
      nxt_s.pmode_ext  = pwdata[4:0] & EXT_AVAIL;
      nxt_s.pmode_wake = pwdata[15:8];
    end
    if (wr && (paddr == irf_pkg::ADDR_CORE_STAT)) begin
      nxt_s.imask = pwdata[irf_pkg::STAT_IMASK];
    end

    //////////////////////////////////////////////////////////////////////////
    // Pending sources, index i carries vector VEC_BASE + i
    // external vectors
    pend[4:0] = s_ff.req_one[4:0] & s_ff.en_one[4:0];
    pend[5] = (|s_ff.wake_req) & s_ff.en_one[irf_pkg::EN1_WAKE];
    pend[6] = s_ff.req_one[irf_pkg::REQ1_SERIAL]
            & s_ff.en_one[irf_pkg::REQ1_SERIAL];
    pend[7] = s_ff.req_one[irf_pkg::REQ1_TIMER_A]
            & s_ff.en_one[irf_pkg::REQ1_TIMER_A];
    pend[8] = s_ff.req_two[irf_pkg::REQ2_INTERVAL]
            & s_ff.en_two[irf_pkg::REQ2_INTERVAL];
    pend[9] = s_ff.req_two[irf_pkg::REQ2_UPDOWN]
            & s_ff.en_two[irf_pkg::REQ2_UPDOWN];
    pend[10] = s_ff.req_two[irf_pkg::REQ2_CMP_LOW]
             & s_ff.en_two[irf_pkg::REQ2_CMP_LOW];
    pend[11] = s_ff.req_two[irf_pkg::REQ2_CMP_HIGH]
             & s_ff.en_two[irf_pkg::REQ2_CMP_HIGH];
    pend[12] = s_ff.req_two[irf_pkg::REQ2_DIRECT]
             & s_ff.en_two[irf_pkg::REQ2_DIRECT];
    pend[13] = s_ff.req_two[irf_pkg::REQ2_CONV]
             & s_ff.en_two[irf_pkg::REQ2_CONV];

    for (int i = irf_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        sel   = 5'(i);
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Core request and acceptance
    // global mask gate
    nxt_s.core_req = found & ~nxt_s.imask;
    nxt_s.core_vec = found ? (irf_pkg::VEC_BASE + sel) : s_ff.core_vec;
    if (core_ack && s_ff.core_req) begin
      nxt_s.imask    = 1'b1;
      nxt_s.core_req = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= irf_pkg::STATE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata   = s_ff.prdata;
  assign pready   = s_ff.pready;
  assign pslverr  = s_ff.pslverr;
  assign core_req = s_ff.core_req;
  assign core_vec = s_ff.core_vec;

endmodule

`default_nettype wire

// *** irf_ctrl_assertions.sv ***
// Concurrent checks on the request flag block ports
`timescale 1ns/1ns
`default_nettype none
module irf_ctrl_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_ack,
  input wire logic        core_req,
  input wire logic [4:0]  core_vec
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Bus and core handshake steps
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_accept;
    core_req && core_ack;
  endsequence
  sequence s_stat_write;
    psel && penable && pready && pwrite && paddr == 8'h1C;
  endsequence
  ////////////////////////////////////////
  AST_READY_WAIT:
    assert property (s_wait |=> pready) else $error("late ready");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready too long");
  AST_READY_IN_XFER:
    assert property (pready |-> psel && penable) else $error("stray ready");
  AST_ERR_READ_ZERO:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("error read not zero");
  AST_ERR_MAPPED:
    assert property (pready && paddr <= 8'h1C && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("error on mapped address");
  AST_RDATA_HOLD:
    assert property (!(pready && !pwrite) |-> $stable(prdata))
    else $error("read data moved");
  AST_ACK_DROPS:
    assert property (s_accept |=> !core_req) else $error("request kept");
  AST_MASK_HOLDS:
    assert property (s_accept |=> !core_req until s_stat_write)
    else $error("request while masked");
  AST_VEC_RANGE:
    assert property (core_req |-> core_vec inside {[5'h04:5'h11]})
    else $error("vector out of range");
endmodule
`default_nettype wire

// *** irf_ctrl_tb_top.sv ***
// Self-checking bench for the request flag block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module irf_ctrl_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite;
  logic [7:0]           paddr, cur;
  logic [31:0]          pwdata, prdata, rdat;
  logic                 pready, pslverr, perr, core_ack, core_req;
  logic [4:0]           ext, core_vec, lvec;
  logic [7:0]           wake;
  logic [3:0]           dly;
  irf_pkg::irf_periph_t pr;
  irf_pkg::irf_timer_t  tm;
  int                   n_errors, comparisons, cyc, n_acc;
  logic [4:0]           vecs [6] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11};
  logic [7:0]           clr [6] = '{8'hCE, 8'hCD, 8'hCB, 8'hC7, 8'h4F, 8'h8F};
  irf_ctrl u_irf_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_req_pin_n(ext), .wake_pin_n(wake), .periph(pr), .timer(tm),
    .core_ack(core_ack), .core_req(core_req), .core_vec(core_vec));
  irf_core_model u_irf_core_model (.pclk(pclk), .presetn(presetn),
    .core_req(core_req), .core_vec(core_vec), .ack_dly(dly),
    .core_ack(core_ack), .last_vec(lvec), .n_acc(n_acc));
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
  endtask
  task automatic wack(input int k);
    for (int i = 0; i < 60 && n_acc < k; i++) @(posedge pclk);
    `CHK(n_acc, k)
  endtask
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext = 5'h1F;
    wake = 8'hFF;
    pr = '0;
    tm = '0;
    tm.cmp_high = 8'h01;
    tm.cmp_low = 8'h01;
    dly = 4'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(irf_pkg::ADDR_REQ_ONE, 32'h0000_0020);
    rd(irf_pkg::ADDR_CORE_STAT, 32'h0000_0080);
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK(perr, 1'b1)
    pr.direct_xfer_evt <= 1'b1;
    tm.updown_cnt <= 8'hFF;
    tm.interval_cnt <= 8'hFF;
    pr.conversion_start_status <= 1'b1;
    tk(1);
    pr.direct_xfer_evt <= 1'b0;
    rd(irf_pkg::ADDR_REQ_TWO, 32'h0000_0002);
    tm.updown_cnt <= 8'h00;
    tm.interval_cnt <= 8'h00;
    pr.conversion_start_status <= 1'b0;
    tm.sixteen_bit <= 1'b1;
    tm.cnt_low <= 8'h01;
    rd(irf_pkg::ADDR_REQ_TWO, 32'h0000_0043);
    tm.cnt_high <= 8'h01;
    pr.direct_xfer_on <= 1'b1;
    pr.direct_xfer_evt <= 1'b1;
    tk(1);
    pr.direct_xfer_evt <= 1'b0;
    rd(irf_pkg::ADDR_REQ_TWO, 32'h0000_00CB);
    wr(irf_pkg::ADDR_REQ_TWO, 32'h0000_00CF);
    rd(irf_pkg::ADDR_REQ_TWO, 32'h0000_00CB);
    tm.sixteen_bit <= 1'b0;
    rd(irf_pkg::ADDR_REQ_TWO, 32'h0000_00CF);
    wr(irf_pkg::ADDR_EN_TWO, 32'h0000_00CF);
    cur = 8'hCF;
    wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wack(i + 1);
      `CHK(lvec, vecs[i])
      rd(irf_pkg::ADDR_REQ_TWO, {24'h00_0000, cur});
      rd(irf_pkg::ADDR_CORE_STAT, {11'h000, vecs[i], 16'h0080});
      wr(irf_pkg::ADDR_REQ_TWO, {24'h00_0000, clr[i]});
      cur = cur & clr[i];
      wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0000);
    end
    wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0080);
    wr(irf_pkg::ADDR_EDGE_SEL, 32'h0000_0001);
    wr(irf_pkg::ADDR_PIN_MODE, 32'h0000_FF17);
    wr(irf_pkg::ADDR_EN_ONE, 32'h0000_0003);
    ext <= 5'h14;
    wake <= 8'hDF;
    tk(8);
    ext <= 5'h15;
    tk(8);
    rd(irf_pkg::ADDR_REQ_ONE, 32'h0000_0023);
    rd(irf_pkg::ADDR_WAKE_REQ, 32'h0000_0020);
    `CHK(n_acc, 6)
    dly <= 4'h4;
    wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0000);
    wack(7);
    `CHK(lvec, 5'h04)
    wr(irf_pkg::ADDR_REQ_ONE, 32'h0000_00FE);
    wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0000);
    wack(8);
    `CHK(lvec, 5'h05)
    wr(irf_pkg::ADDR_REQ_ONE, 32'h0000_00FD);
    wr(irf_pkg::ADDR_CORE_STAT, 32'h0000_0000);
    tk(10);
    `CHK(core_req, 1'b0)
    `CHK(n_acc, 8)
    wr(irf_pkg::ADDR_EN_ONE, 32'h0000_0020);
    wack(9);
    `CHK(lvec, 5'h09)
    rd(irf_pkg::ADDR_WAKE_REQ, 32'h0000_0020);
    test_done();
  end
endmodule
bind irf_ctrl irf_ctrl_assertions u_irf_ctrl_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .core_ack(core_ack), .core_req(core_req),
  .core_vec(core_vec));
`default_nettype wire

// *** irf_pin_sync.sv ***
// Two-stage pin synchroniser with rise and fall detection per pin
`timescale 1ns/1ns
`default_nettype none

module irf_pin_sync #(
  parameter int W = 13
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_n,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] prev;
  } irf_sync_t;

  irf_sync_t s_ff;
  irf_sync_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Only stage2 and prev feed the edge logic
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.stage1 = pin_n;
    nxt_s.stage2 = s_ff.stage1;
    nxt_s.prev   = s_ff.stage2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{stage1: '1, stage2: '1, prev: '1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rise = s_ff.stage2 & ~s_ff.prev;
  assign fall = ~s_ff.stage2 & s_ff.prev;

endmodule

`default_nettype wire

// *** irf_pkg.sv ***
// Shared constants, register map and carrier types for the request flags
`default_nettype none
package irf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_REQ_ONE   = 8'h00;
  localparam logic [7:0] ADDR_REQ_TWO   = 8'h04;
  localparam logic [7:0] ADDR_WAKE_REQ  = 8'h08;
  localparam logic [7:0] ADDR_EN_ONE    = 8'h0C;
  localparam logic [7:0] ADDR_EN_TWO    = 8'h10;
  localparam logic [7:0] ADDR_EDGE_SEL  = 8'h14;
  localparam logic [7:0] ADDR_PIN_MODE  = 8'h18;
  localparam logic [7:0] ADDR_CORE_STAT = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int REQ1_TIMER_A   = 7;
  localparam int REQ1_SERIAL    = 6;
  localparam int REQ1_FIXED_ONE = 5;
  localparam int REQ2_DIRECT    = 7;
  localparam int REQ2_CONV      = 6;
  localparam int REQ2_CMP_HIGH  = 3;
  localparam int REQ2_CMP_LOW   = 2;
  localparam int REQ2_UPDOWN    = 1;
  localparam int REQ2_INTERVAL  = 0;
  localparam int EN1_WAKE       = 5;
  localparam int STAT_IMASK     = 7;
  localparam int STAT_REQ       = 8;
  localparam int STAT_VEC_LSB   = 16;

  // Implemented bits of both request flag registers, and the full and reduced variant masks
  localparam logic [7:0] REQ1_IMPL      = 8'hDF;
  localparam logic [7:0] REQ2_IMPL      = 8'hCF;
  localparam logic [4:0] EXT_FULL       = 5'h1F;
  localparam logic [4:0] EXT_REDUCED    = 5'h1B;
  localparam logic [7:0] REQ1_REDUCED   = 8'hBF;
  localparam logic [7:0] REQ2_REDUCED   = 8'hFD;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  REQ_ONE_RST   = 8'h00;
  localparam logic [7:0]  REQ_TWO_RST   = 8'h00;
  localparam logic [7:0]  WAKE_REQ_RST  = 8'h00;
  localparam logic [7:0]  EN_RST        = 8'h00;
  localparam logic [4:0]  EDGE_RST      = 5'h00;
  localparam logic [4:0]  PMODE_EXT_RST = 5'h00;
  localparam logic [7:0]  PMODE_WK_RST  = 8'h00;
  localparam logic        IMASK_RST     = 1'b1;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Counts, vectors and pin groups
  localparam int         NUM_EXT   = 5;
  localparam int         NUM_WAKE  = 8;
  localparam int         NUM_PINS  = 13;
  localparam int         NUM_SRC   = 14;
  localparam logic [4:0] VEC_BASE  = 5'h04;
  localparam logic [7:0] CNT_TOP   = 8'hFF;
  localparam logic [7:0] CNT_ZERO  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic direct_xfer_evt;
    logic direct_xfer_on;
    logic conversion_start_status;
    logic serial1_done;
  } irf_periph_t;

  typedef struct packed {
    logic       sixteen_bit;
    logic [7:0] cnt_high;
    logic [7:0] cnt_low;
    logic [7:0] cmp_high;
    logic [7:0] cmp_low;
    logic [7:0] updown_cnt;
    logic [7:0] interval_cnt;
    logic [7:0] timer_a_cnt;
  } irf_timer_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  req_one;
    logic [7:0]  req_two;
    logic [7:0]  wake_req;
    logic [7:0]  en_one;
    logic [7:0]  en_two;
    logic [4:0]  edge_sel;
    logic [4:0]  pmode_ext;
    logic [7:0]  pmode_wake;
    logic        imask;
    logic        core_req;
    logic [4:0]  core_vec;
    logic        match_h_prev;
    logic        match_l_prev;
    logic        conv_prev;
    logic [7:0]  updown_prev;
    logic [7:0]  interval_prev;
    logic [7:0]  timer_a_prev;
  } irf_state_t;

  localparam irf_state_t STATE_RST = '{
    pready:        1'b0,
    pslverr:       1'b0,
    prdata:        RDATA_RST,
    req_one:       REQ_ONE_RST,
    req_two:       REQ_TWO_RST,
    wake_req:      WAKE_REQ_RST,
    en_one:        EN_RST,
    en_two:        EN_RST,
    edge_sel:      EDGE_RST,
    pmode_ext:     PMODE_EXT_RST,
    pmode_wake:    PMODE_WK_RST,
    imask:         IMASK_RST,
    core_req:      1'b0,
    core_vec:      5'h00,
    match_h_prev:  1'b0,
    match_l_prev:  1'b0,
    conv_prev:     1'b0,
    updown_prev:   CNT_ZERO,
    interval_prev: CNT_ZERO,
    timer_a_prev:  CNT_ZERO
  };

endpackage

`default_nettype wire
